// file: common/stp_pkg.sv
`default_nettype none

package stp_pkg;

  // ************************************************************
  // Clock and flash timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FLASH_TIME_MS = 100;
  // Display duration, so rounded down
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_TIME_MS;

  // ************************************************************
  // Test numbers (octal figures held in binary)
  // ************************************************************
  localparam logic [3:0] TEST_FIRST = 4'hF; // octal 17, sequencers
  localparam logic [3:0] TEST_ALU = 4'hE;   // octal 16
  localparam logic [3:0] TEST_BIC = 4'hD;   // octal 15
  localparam logic [3:0] TEST_FIFO = 4'hC;  // octal 14
  localparam logic [3:0] TEST_FMT = 4'hA;   // octal 12, formatter
  localparam logic [3:0] TEST_LAST = 4'h3;
  localparam logic [3:0] TEST_TUNE = 4'h2;
  localparam logic [3:0] TEST_SEEK = 4'h1;
  localparam logic [3:0] TEST_SUITE = 4'h0;

  // ************************************************************
  // Result display and formatter subtest figures
  // ************************************************************
  localparam logic [3:0] LED_ALL = 4'hF;
  localparam logic [3:0] LED_OFF = 4'h0;
  localparam logic [3:0] SEC_NO_EOW = 4'hA;     // octal 12
  localparam logic [3:0] SEC_W8_TRUE = 4'h9;    // octal 11
  localparam logic [3:0] SEC_W8_FALSE = 4'h8;   // octal 10
  localparam logic [1:0] SUB_LAST = 2'h2;       // third subtest
  localparam logic [3:0] EOW_WORDS = 4'h8;      // 16 bytes

  typedef enum logic [3:0] {
    S_LAMP, S_LAUNCH, S_WAIT, S_SHOW, S_HALT,
    S_HANG, S_SELF_LOOP, S_EXIT, S_TUNE, S_SEEK
  } stp_state_e;

endpackage

`default_nettype wire

// file: verilog/stp_flash_timer.sv
`default_nettype none

module stp_flash_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic start_i,
  output logic done_o
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;
  logic run_reg;

  // ************************************************************
  // One-shot down counter, done is a one-cycle pulse
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // Restart wins so a blink never misses its next period
        cnt_reg <= W'(CYCLES - 1);
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg == '0) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/stp_self_test_sequencer.sv
// Behaviour
// - Operating start press runs suite once; 17-15 errors hang, lower exit.
// - Operating with start held loops suite, restarting on error except test 17, until release.
// - Held start flashes all LEDs each pass and withholds errors.
// - Service n>2 loops test n until error, halts; test 17 hangs.
// - Single loop flashes n per pass; error shows section for tests 14 down, failure lit.
// - Service test 2 runs the bus interface chip tuning, flashes 2.
// - Service test 1 commands random seeks, flashes 1.
// - Service test 0 loops suite, flashing numbers; error halts showing test, test 17 hangs.
// - Test 17 failure clears only by reset; 16/15 hang clear on start.
// - Service with start held restarts after errors, except test 17.
// - Service position makes the controller ignore all bus commands.
// - Test number switches only count in service; start is momentary.
// - Every run except service tests 2 and 1 flashes all indicators; front failure mirrors rear failure.
// - Test 17 fault enters jump_to_self_loop showing 17, no sections.
// - Test 16 failure hangs showing 16 in operating mode unless start held; start exits.
// - Test 15 failure shows 15 and hangs in operating mode; in service it halts.
// - Test 14 is first to report sections and exit after error.
// - Test 13 loops data through bus interface chip and FIFO.
// - Formatter subtest one compares looped-back pattern with original.
// - Formatter subtest two expects overrun from reading an empty FIFO.
// - Formatter subtest three: eighth-word flag only after sixteenth byte.
// - Tests run 17 down to 3; all LEDs on at start, off on pass.
`default_nettype none

module stp_self_test_sequencer #(
  parameter int unsigned FLASH_CYCLES = stp_pkg::FLASH_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic test_mode_switch_i,
  input wire logic [3:0] test_number_i,
  input wire logic start_i,
  input wire logic test_done_i,
  input wire logic test_err_i,
  input wire logic [3:0] test_section_i,
  input wire logic end_of_word_flag_i,
  input wire logic eighth_word_flag_i,
  output logic [3:0] result_led_o,
  output logic fail_led_o,
  output logic front_fail_o,
  output logic test_go_o,
  output logic [3:0] test_id_o,
  output logic [1:0] subtest_o,
  output logic tune_run_o,
  output logic random_seek_o,
  output logic firmware_exit_o,
  output logic hung_o,
  output logic jump_to_self_loop_o,
  output logic bus_cmd_ignore_o
);

  stp_pkg::stp_state_e state_reg;
  stp_pkg::stp_state_e state_q;
  stp_pkg::stp_state_e beg_state;
  logic [3:0] cur_reg;
  logic [1:0] sub_reg;
  logic single_reg;
  logic [3:0] disp_reg;
  logic fail_reg;
  logic [3:0] pend_reg;
  logic pend_v_reg;
  logic start_q;
  logic start_rise;
  logic svc;
  logic [3:0] beg_cur;
  logic beg_single;
  logic [3:0] eow_cnt_reg;
  logic [3:0] eow_now;
  logic early_reg;
  logic chk_err;
  logic [3:0] chk_sec;
  logic err;
  logic [3:0] code;
  logic hang_code;
  logic blink_reg;
  logic flash_go;
  logic flash_done;
  logic w8_check;

  assign svc = test_mode_switch_i;
  assign start_rise = start_i & ~start_q;

  // ************************************************************
  // Flash timer for lamp test, pass flashes and tuning blink
  // ************************************************************
  assign flash_go = ((state_reg != state_q) &&
                     (state_reg inside {stp_pkg::S_LAMP, stp_pkg::S_SHOW,
                                        stp_pkg::S_TUNE, stp_pkg::S_SEEK}))
                    || (flash_done &&
                        (state_reg inside {stp_pkg::S_TUNE,
                                           stp_pkg::S_SEEK}));

  stp_flash_timer #(
    .CYCLES(FLASH_CYCLES)
  ) u_flash (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .start_i(flash_go),
    .done_o(flash_done)
  );

  // ************************************************************
  // Run selection from the panel
  // ************************************************************
  // Switches read only in service; any other case runs the suite
  always_comb begin
    beg_state = stp_pkg::S_LAMP;
    beg_cur = stp_pkg::TEST_FIRST;
    beg_single = 1'b0;
    if (svc) begin
      if (test_number_i == stp_pkg::TEST_TUNE) begin
        beg_state = stp_pkg::S_TUNE;
      end else if (test_number_i == stp_pkg::TEST_SEEK) begin
        beg_state = stp_pkg::S_SEEK;
      end else if (test_number_i != stp_pkg::TEST_SUITE) begin
        beg_cur = test_number_i;
        beg_single = 1'b1;
      end
    end
  end

  // ************************************************************
  // Eighth-word check of the third formatter subtest
  // ************************************************************
  assign w8_check = (state_reg == stp_pkg::S_WAIT) &&
                    (cur_reg == stp_pkg::TEST_FMT) &&
                    (sub_reg == stp_pkg::SUB_LAST);
  assign eow_now = eow_cnt_reg + {3'h0, end_of_word_flag_i};

  // Early flag latches; count saturates at eight words
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || state_reg == stp_pkg::S_LAUNCH) begin
      eow_cnt_reg <= 4'h0;
      early_reg <= 1'b0;
    end else if (w8_check) begin
      if (end_of_word_flag_i && eow_cnt_reg != stp_pkg::EOW_WORDS) begin
        eow_cnt_reg <= eow_now;
      end
      if (eighth_word_flag_i && eow_now < stp_pkg::EOW_WORDS) begin
        early_reg <= 1'b1;
      end
    end
  end

  // Engine errors first, then the local flag check
  always_comb begin
    chk_err = 1'b0;
    chk_sec = stp_pkg::LED_OFF;
    if (w8_check) begin
      if (eow_now < stp_pkg::EOW_WORDS) begin
        chk_err = 1'b1;
        chk_sec = stp_pkg::SEC_NO_EOW;
      end else if (early_reg) begin
        chk_err = 1'b1;
        chk_sec = stp_pkg::SEC_W8_TRUE;
      end else if (!eighth_word_flag_i) begin
        chk_err = 1'b1;
        chk_sec = stp_pkg::SEC_W8_FALSE;
      end
    end
  end

  assign err = test_err_i | chk_err;
  // Tests 17 to 15 have no sections, so they report their own number
  assign code = (single_reg && cur_reg <= stp_pkg::TEST_FIFO) ?
                (test_err_i ? test_section_i : chk_sec) : cur_reg;
  assign hang_code = (cur_reg == stp_pkg::TEST_ALU) ||
                     (cur_reg == stp_pkg::TEST_BIC);

  // ************************************************************
  // Test sequencer
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      // Reset is power-on or run/stop: run the suite at once
      state_reg <= stp_pkg::S_LAMP;
      state_q <= stp_pkg::S_EXIT;
      cur_reg <= stp_pkg::TEST_FIRST;
      sub_reg <= 2'h0;
      single_reg <= 1'b0;
      disp_reg <= stp_pkg::LED_OFF;
      fail_reg <= 1'b0;
      pend_reg <= stp_pkg::LED_OFF;
      pend_v_reg <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= start_i;
      state_q <= state_reg;
      unique case (state_reg)
        stp_pkg::S_LAMP: begin
          sub_reg <= 2'h0;
          if (flash_done) begin
            state_reg <= stp_pkg::S_LAUNCH;
          end
        end
        stp_pkg::S_LAUNCH: begin
          state_reg <= stp_pkg::S_WAIT;
        end
        stp_pkg::S_WAIT: begin
          if (test_done_i && !err) begin
            if (cur_reg == stp_pkg::TEST_FMT &&
                sub_reg != stp_pkg::SUB_LAST) begin
              sub_reg <= sub_reg + 2'h1;
              state_reg <= stp_pkg::S_LAUNCH;
            end else if (svc) begin
              sub_reg <= 2'h0;
              state_reg <= stp_pkg::S_SHOW;
            end else if (cur_reg != stp_pkg::TEST_LAST) begin
              sub_reg <= 2'h0;
              cur_reg <= cur_reg - 4'h1;
              state_reg <= stp_pkg::S_LAUNCH;
            end else if (start_i) begin
              cur_reg <= stp_pkg::TEST_FIRST;
              state_reg <= stp_pkg::S_LAMP;
            end else if (pend_v_reg) begin
              // Withheld error shown once start is let go
              pend_v_reg <= 1'b0;
              disp_reg <= pend_reg;
              fail_reg <= 1'b1;
              state_reg <= (pend_reg == stp_pkg::TEST_ALU ||
                            pend_reg == stp_pkg::TEST_BIC) ?
                           stp_pkg::S_HANG : stp_pkg::S_EXIT;
            end else begin
              disp_reg <= stp_pkg::LED_OFF;
              fail_reg <= 1'b0;
              state_reg <= stp_pkg::S_EXIT;
            end
          end else if (test_done_i) begin
            sub_reg <= 2'h0;
            if (cur_reg == stp_pkg::TEST_FIRST) begin
              state_reg <= stp_pkg::S_SELF_LOOP;
            end else if (start_i) begin
              // Held start turns the error into a restart
              if (!svc) begin
                pend_reg <= code;
                pend_v_reg <= 1'b1;
                cur_reg <= stp_pkg::TEST_FIRST;
              end else if (!single_reg) begin
                cur_reg <= stp_pkg::TEST_FIRST;
              end
              state_reg <= stp_pkg::S_LAMP;
            end else begin
              disp_reg <= code;
              fail_reg <= 1'b1;
              pend_v_reg <= 1'b0;
              if (svc) begin
                state_reg <= stp_pkg::S_HALT;
              end else if (hang_code) begin
                state_reg <= stp_pkg::S_HANG;
              end else begin
                state_reg <= stp_pkg::S_EXIT;
              end
            end
          end
        end
        stp_pkg::S_SHOW: begin
          if (flash_done) begin
            if (!single_reg) begin
              cur_reg <= (cur_reg == stp_pkg::TEST_LAST) ?
                         stp_pkg::TEST_FIRST : cur_reg - 4'h1;
            end
            state_reg <= stp_pkg::S_LAUNCH;
          end
        end
        stp_pkg::S_SELF_LOOP: begin
          state_reg <= stp_pkg::S_SELF_LOOP;
        end
        stp_pkg::S_TUNE, stp_pkg::S_SEEK: begin
          if (!svc) begin
            state_reg <= stp_pkg::S_EXIT;
          end else if (start_rise) begin
            state_reg <= beg_state;
            cur_reg <= beg_cur;
            single_reg <= beg_single;
          end
        end
        stp_pkg::S_HALT, stp_pkg::S_HANG, stp_pkg::S_EXIT: begin
          // Start press leaves a halt or a 16/15 hang
          if (start_rise) begin
            state_reg <= beg_state;
            cur_reg <= beg_cur;
            single_reg <= beg_single;
            fail_reg <= 1'b0;
            pend_v_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Panel indicators
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      result_led_o <= stp_pkg::LED_OFF;
      fail_led_o <= 1'b0;
      front_fail_o <= 1'b0;
      blink_reg <= 1'b0;
    end else begin
      if (flash_go) begin
        blink_reg <= ~blink_reg;
      end
      unique case (state_reg)
        stp_pkg::S_LAMP: begin
          result_led_o <= stp_pkg::LED_ALL;
          fail_led_o <= 1'b1;
          front_fail_o <= 1'b1;
        end
        stp_pkg::S_SHOW: begin
          result_led_o <= cur_reg;
          fail_led_o <= 1'b0;
          front_fail_o <= 1'b0;
        end
        stp_pkg::S_SELF_LOOP: begin
          result_led_o <= stp_pkg::TEST_FIRST;
          fail_led_o <= 1'b1;
          front_fail_o <= 1'b1;
        end
        stp_pkg::S_TUNE, stp_pkg::S_SEEK: begin
          result_led_o <= blink_reg ? test_id_o : stp_pkg::LED_OFF;
          fail_led_o <= 1'b0;
          front_fail_o <= 1'b0;
        end
        stp_pkg::S_HALT, stp_pkg::S_HANG, stp_pkg::S_EXIT: begin
          result_led_o <= disp_reg;
          fail_led_o <= fail_reg;
          front_fail_o <= fail_reg;
        end
        default: begin
          // Running: nothing shown, so held errors stay hidden
          result_led_o <= stp_pkg::LED_OFF;
          fail_led_o <= 1'b0;
          front_fail_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Engine strobes and controller status
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      test_go_o <= 1'b0;
      test_id_o <= stp_pkg::TEST_FIRST;
      subtest_o <= 2'h0;
      tune_run_o <= 1'b0;
      random_seek_o <= 1'b0;
      firmware_exit_o <= 1'b0;
      hung_o <= 1'b0;
      jump_to_self_loop_o <= 1'b0;
      bus_cmd_ignore_o <= 1'b1;
    end else begin
      test_go_o <= (state_reg == stp_pkg::S_LAUNCH);
      test_id_o <= (state_reg == stp_pkg::S_TUNE) ? stp_pkg::TEST_TUNE :
                   (state_reg == stp_pkg::S_SEEK) ? stp_pkg::TEST_SEEK :
                   cur_reg;
      subtest_o <= sub_reg;
      tune_run_o <= (state_reg == stp_pkg::S_TUNE);
      random_seek_o <= (state_reg == stp_pkg::S_SEEK);
      firmware_exit_o <= (state_reg == stp_pkg::S_EXIT);
      hung_o <= (state_reg inside {stp_pkg::S_HANG, stp_pkg::S_SELF_LOOP});
      jump_to_self_loop_o <= (state_reg == stp_pkg::S_SELF_LOOP);
      bus_cmd_ignore_o <= svc || (state_reg != stp_pkg::S_EXIT);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_err_done;
    state_reg == stp_pkg::S_WAIT && test_done_i && test_err_i;
  endsequence

  sequence s_show_17;
    result_led_o == stp_pkg::TEST_FIRST && fail_led_o && jump_to_self_loop_o;
  endsequence

  a_self_loop_hold: assert property (
    s_err_done ##0 cur_reg == stp_pkg::TEST_FIRST |=> ##1 s_show_17 [*3])
    else $error("test 17 fault did not hold the self loop display");

  a_op_hang_alu: assert property (
    s_err_done ##0 !svc && !start_i && cur_reg == stp_pkg::TEST_ALU
    |=> ##1 hung_o && result_led_o == stp_pkg::TEST_ALU && fail_led_o)
    else $error("test 16 error did not hang showing 16");

  a_op_hang_bic: assert property (
    s_err_done ##0 !svc && !start_i && cur_reg == stp_pkg::TEST_BIC
    |=> ##1 hung_o && result_led_o == stp_pkg::TEST_BIC)
    else $error("test 15 error did not hang showing 15");

  a_op_exit_low: assert property (
    s_err_done ##0 !svc && !start_i && cur_reg <= stp_pkg::TEST_FIFO
    |=> ##1 firmware_exit_o && fail_led_o && !hung_o)
    else $error("low test error did not exit to firmware");

  a_svc_halt: assert property (
    s_err_done ##0 svc && !start_i && cur_reg != stp_pkg::TEST_FIRST
    |=> state_reg == stp_pkg::S_HALT ##1 fail_led_o [*2])
    else $error("service error did not halt with failure lit");

  a_held_hidden: assert property (
    !svc && start_i && state_reg == stp_pkg::S_WAIT |=> !fail_led_o)
    else $error("error shown while start held");

  a_lamp_all: assert property (
    state_reg == stp_pkg::S_LAMP |=> result_led_o == stp_pkg::LED_ALL)
    else $error("lamp test did not light every LED");

  a_front_mirror: assert property (
    front_fail_o == fail_led_o)
    else $error("front failure differs from rear failure");

  a_svc_ignore: assert property (
    svc |=> bus_cmd_ignore_o)
    else $error("bus commands not ignored in service");

  a_w8_early: assert property (
    w8_check && test_done_i && !test_err_i && early_reg &&
    eow_now >= stp_pkg::EOW_WORDS && svc && single_reg && !start_i
    |=> disp_reg == stp_pkg::SEC_W8_TRUE)
    else $error("early eighth-word flag not reported");

endmodule

`default_nettype wire

// file: tb/stp_engine_model.sv
`default_nettype none

module stp_engine_model (
  input wire logic clk_sys_i,
  input wire logic test_go_i,
  input wire logic [3:0] test_id_i,
  input wire logic [1:0] subtest_i,
  input wire logic fail_en_i,
  input wire logic [3:0] fail_id_i,
  input wire logic [3:0] fail_sec_i,
  input wire logic [3:0] delay_i,
  input wire logic early_i,
  output logic done_o,
  output logic err_o,
  output logic [3:0] section_o,
  output logic end_of_word_flag_o,
  output logic eighth_word_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Test engine: one answer for every launch
  // ************************************************************
  logic [3:0] id_reg;
  logic [1:0] sub_reg;
  logic bad;
  initial begin
    done_o = 1'b0;
    err_o = 1'b0;
    section_o = 4'h0;
    end_of_word_flag_o = 1'b0;
    eighth_word_flag_o = 1'b0;
  end
  // Section lines scramble after done, so a stale value never matches
  always begin
    // Launch taken mid-cycle, clear of the edge that moves it
    @(negedge clk_sys_i iff test_go_i === 1'b1);
    id_reg = test_id_i;
    sub_reg = subtest_i;
    bad = fail_en_i && (id_reg == fail_id_i);
    eighth_word_flag_o = 1'b0;
    repeat (delay_i) @(negedge clk_sys_i);
    if (id_reg == stp_pkg::TEST_FMT && sub_reg == stp_pkg::SUB_LAST) begin
      // Flag rises after the eighth word has gone
      for (int w = 1; w <= 8; w++) begin
        @(negedge clk_sys_i);
        end_of_word_flag_o = 1'b1;
        @(negedge clk_sys_i);
        end_of_word_flag_o = 1'b0;
        // Early mode raises the flag one word too soon
        eighth_word_flag_o = (w == 8) || (early_i && w == 7);
      end
    end
    @(negedge clk_sys_i);
    done_o = 1'b1;
    err_o = bad;
    section_o = fail_sec_i;
    @(negedge clk_sys_i);
    done_o = 1'b0;
    err_o = 1'b0;
    section_o = ~section_o;
  end
endmodule

`default_nettype wire

// file: tb/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Stimulus, design and engine
  // ************************************************************
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic mode = 1'b0;
  logic start = 1'b0;
  logic fail_en = 1'b0;
  logic [3:0] num = 4'h0;
  logic [3:0] fail_id = 4'hF;
  logic [3:0] fail_sec = 4'h0;
  logic [3:0] dly = 4'h0;
  logic early = 1'b0;
  logic done, err, end_of_word_flag, eighth, fail_led, front, go, tune, seek;
  logic fexit, hung, jloop, ign;
  logic [3:0] sec, led, tid;
  logic [1:0] sub;
  logic [5:0] ids[$];
  int num_errors = 0;
  int n_compared = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  stp_self_test_sequencer #(.FLASH_CYCLES(8)) stp_self_test_sequencer_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .test_mode_switch_i(mode),
    .test_number_i(num), .start_i(start), .test_done_i(done),
    .test_err_i(err), .test_section_i(sec), .end_of_word_flag_i(end_of_word_flag),
    .eighth_word_flag_i(eighth), .result_led_o(led), .fail_led_o(fail_led),
    .front_fail_o(front), .test_go_o(go), .test_id_o(tid),
    .subtest_o(sub), .tune_run_o(tune), .random_seek_o(seek),
    .firmware_exit_o(fexit), .hung_o(hung), .jump_to_self_loop_o(jloop),
    .bus_cmd_ignore_o(ign));

  stp_engine_model stp_engine_model_inst (
    .clk_sys_i(clk_sys_i), .test_go_i(go), .test_id_i(tid),
    .subtest_i(sub), .fail_en_i(fail_en), .fail_id_i(fail_id),
    .fail_sec_i(fail_sec), .delay_i(dly), .early_i(early), .done_o(done),
    .err_o(err), .section_o(sec), .end_of_word_flag_o(end_of_word_flag),
    .eighth_word_flag_o(eighth));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Press from a settled state; held presses leave the switch up
  task automatic press(input logic hold);
    @(negedge clk_sys_i);
    ids.delete();
    start = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    start = hold;
  endtask

  // Bounded wait: 0 stopped, 1 LED value, 2 launch of a test
  task automatic wait_for(input int kind, input logic [3:0] v);
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 4000 && !hit; i++) begin
      @(negedge clk_sys_i);
      case (kind)
        0: hit = fexit === 1'b1 || hung === 1'b1 ||
                 (fail_led === 1'b1 && led !== 4'hF);
        1: hit = led === v;
        default: hit = go === 1'b1 && tid === v;
      endcase
    end
    check({3'h0, hit}, 4'h1);
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Launch log; front lamp watched against the rear one every cycle out of reset
  always @(negedge clk_sys_i) begin
    if (go === 1'b1) ids.push_back({sub, tid});
    if (srst_i === 1'b0) check({3'h0, front}, {3'h0, fail_led});
  end

  // Whole run is under a thousand cycles; the watchdog allows 50,000
  initial begin
    #2_000_000;
    num_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    test_done();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    int t;
    logic [5:0] e[$];
    fail_en = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check(tid, 4'hF);
    check({3'h0, ign}, 4'h1);
    srst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check(led, stp_pkg::LED_ALL);
    check({3'h0, fail_led}, 4'h1);
    wait_for(0, 4'h0);
    check(led, 4'hF);
    check({jloop, hung}, 4'h3);
    press(1'b0);
    repeat (20) @(negedge clk_sys_i);
    check({jloop, 3'(ids.size())}, 4'h8);
    $display("test ended: first test fault");
    srst_i = 1'b1;
    fail_en = 1'b0;
    dly = 4'h3;
    repeat (4) @(negedge clk_sys_i);
    srst_i = 1'b0;
    ids.delete();
    wait_for(0, 4'h0);
    check({fexit, fail_led, ign, hung}, 4'h8);
    check(led, stp_pkg::LED_OFF);
    for (t = 15; t >= 3; t--) begin
      e.push_back({2'h0, t[3:0]});
      if (t == 10) e.push_back(6'h1A);
      if (t == 10) e.push_back(6'h2A);
    end
    check({3'h0, ids.size() == e.size()}, 4'h1);
    foreach (e[k]) begin
      check(ids[k][3:0], e[k][3:0]);
      check({2'h0, ids[k][5:4]}, {2'h0, e[k][5:4]});
    end
    $display("test ended: operating pass");
    fail_en = 1'b1;
    fail_id = 4'hC;
    fail_sec = 4'h5;
    press(1'b0);
    wait_for(0, 4'h0);
    check(led, 4'hC);
    check({fexit, fail_led, hung, ign}, 4'hC);
    check(ids[ids.size() - 1][3:0], 4'hC);
    fail_id = 4'hE;
    press(1'b0);
    wait_for(0, 4'h0);
    check(led, 4'hE);
    check({fexit, fail_led, hung, ign}, 4'h7);
    fail_id = 4'hD;
    press(1'b0);
    wait_for(0, 4'h0);
    check(led, 4'hD);
    check({3'h0, hung}, 4'h1);
    $display("test ended: operating errors");
    fail_id = 4'hB;
    press(1'b1);
    wait_for(2, 4'hB);
    wait_for(2, 4'hE);
    t = 0;
    foreach (ids[k]) if (ids[k][3:0] == 4'hF) t++;
    check({3'h0, t == 2}, 4'h1);
    check({3'h0, fail_led}, 4'h0);
    start = 1'b0;
    wait_for(0, 4'h0);
    check(led, 4'hB);
    check({2'h0, fexit, fail_led}, 4'h3);
    $display("test ended: held start");
    mode = 1'b1;
    num = 4'hC;
    fail_en = 1'b0;
    press(1'b0);
    wait_for(1, 4'hC);
    wait_for(2, 4'hC);
    check({3'h0, ign}, 4'h1);
    fail_en = 1'b1;
    fail_id = 4'hC;
    wait_for(0, 4'h0);
    check(led, 4'h5);
    check({fexit, fail_led, hung, ign}, 4'h5);
    num = 4'h2;
    press(1'b0);
    wait_for(1, 4'h2);
    check(tid, 4'h2);
    check({3'h0, tune}, 4'h1);
    num = 4'h1;
    press(1'b0);
    wait_for(1, 4'h1);
    check({2'h0, seek, tune}, 4'h2);
    $display("test ended: service single");
    num = 4'h0;
    fail_id = 4'hA;
    fail_sec = 4'h3;
    press(1'b0);
    wait_for(0, 4'h0);
    check(led, 4'hA);
    check({3'h0, fail_led}, 4'h1);
    for (t = 0; t < 5; t++) check(ids[t][3:0], 4'hF - t[3:0]);
    num = 4'hE;
    fail_id = 4'hE;
    press(1'b1);
    wait_for(2, 4'hE);
    wait_for(2, 4'hE);
    check({3'h0, hung}, 4'h0);
    start = 1'b0;
    wait_for(0, 4'h0);
    check(led, 4'hE);
    $display("test ended: service suite and held");
    // Single formatter loop with the eighth-word flag raised early
    early = 1'b1;
    fail_en = 1'b0;
    num = 4'hA;
    press(1'b0);
    wait_for(0, 4'h0);
    check(led, stp_pkg::SEC_W8_TRUE);
    check({2'h0, fail_led, hung}, 4'h2);
    check({2'h0, ids[2][5:4]}, 4'h2);
    $display("test ended: early eighth word");
    test_done();
  end
endmodule

`default_nettype wire
